// file: rtl/fpt_pkg.sv
// Package: register map, field positions, reset values and state types of the timer
package fpt_pkg;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;
    localparam int THR_W = 5;
    localparam int EV_W = NUM_CH + 1;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_MODULO_VALUE = 8'h08;
    localparam logic [7:0] OFS_COUNTER_INITIAL = 8'h0C;
    localparam logic [7:0] OFS_TIMER_CONFIGURATION = 8'h20;
    localparam logic [7:0] OFS_LOAD_ENABLE = 8'h24;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h28;
    localparam logic [7:0] OFS_EVENT_CLEAR = 8'h2C;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h30;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
    localparam logic [7:0] OFS_CH_VALUE = 8'h04;

    // Field positions
    localparam int SC_RUN_BIT = 0;
    localparam int SC_IRQ_EN_BIT = 6;
    localparam int SC_FLAG_BIT = 7;
    localparam int TIMER_CONFIGURATION_THR_LSB = 0;
    localparam int TIMER_CONFIGURATION_DBG_LSB = 6;
    localparam int CH_TOGGLE_BIT = 0;
    localparam int CH_IRELOAD_BIT = 1;
    localparam int LOAD_OK_BIT = 9;

    // Reset values and codes
    localparam logic [CNT_W-1:0] RST_MODULO = 16'hFFFF;
    localparam logic [1:0] DBG_MODE_RUN = 2'h0;

    // Channel state
    typedef struct packed {
        logic pin;
    } fpt_ch_state_type;

    // Timer state
    typedef struct packed {
        logic run;
        logic irq_en;
        logic flag;
        logic clr_armed;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] modv;
        logic [CNT_W-1:0] init;
        logic [CNT_W-1:0] mod_buf;
        logic [CNT_W-1:0] init_buf;
        logic [NUM_CH*CNT_W-1:0] chv;
        logic [NUM_CH*CNT_W-1:0] chv_buf;
        logic [NUM_CH-1:0] ch_tog;
        logic [NUM_CH-1:0] ch_irl;
        logic [THR_W-1:0] thr;
        logic [THR_W-1:0] ovf_cnt;
        logic [1:0] dbg_sel;
        logic load_ok;
        logic [NUM_CH-1:0] load_sel;
        logic [EV_W-1:0] ev_st;
        logic [EV_W-1:0] ev_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } fpt_state_type;
endpackage

// file: rtl/fpt_channel.sv
// Module: one compare channel with match detect and toggled output pin
module fpt_channel (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic step,
    input wire logic [fpt_pkg::CNT_W-1:0] cnt_nxt,
    input wire logic [fpt_pkg::CNT_W-1:0] ch_value,
    input wire logic toggle_en,
    output logic match,
    output logic pin_out
);
    import fpt_pkg::*;

    fpt_ch_state_type s_r;
    fpt_ch_state_type s_nxt;

    // Match only on a real counter advance, so a reload never repeats it
    assign match = step && (cnt_nxt == ch_value);

    // Toggle once per genuine match
    always_comb begin
        s_nxt = s_r;
        if (match && toggle_en) begin
            s_nxt.pin = ~s_r.pin;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_out = s_r.pin;
endmodule

// file: rtl/fpt_timer.sv
// Module: PWM/compare timer with buffered reload, APB registers and interrupt
//
// Summary of operation
// - Debug session with nonzero select halts counter
// - Load-enable writes that leave out the load-ok byte lane keep load-ok untouched
// - Load-ok gates buffered transfer at reload point
// - Intermediate reload match gives exactly one event
// - Toggle mode inverts output once per match
// - Match coincident with other reload stays single
// - Read-then-write-zero clears flag unless an overflow sets it in that cycle
// - Nonzero threshold counts overflows before flagging
// - Interrupt follows flag while interrupt enable set, ORed with enabled events
//
// The placing of the registers and the APB register port were chosen for this implementation.
module fpt_timer (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic debug_active,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [fpt_pkg::NUM_CH-1:0] ch_out
);
    import fpt_pkg::*;

    fpt_state_type s_r;
    fpt_state_type s_nxt;
    logic step;
    logic wrap;
    logic reload;
    logic [CNT_W-1:0] cnt_nxt;
    logic [NUM_CH-1:0] match;
    logic [31:0] rv;
    logic [31:0] wv;
    logic hit;
    logic wr_fire;
    logic rd_fire;
    logic clr_ok;
    logic ovf_set;

    // Byte-lane merge of write data over the current register value
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            lane_merge[8*b +: 8] = st[b] ? wd[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    // Counter advance, wrap and reload point
    assign step = s_r.run && !(debug_active && s_r.dbg_sel != DBG_MODE_RUN);
    assign wrap = step && (s_r.cnt == s_r.modv);
    assign cnt_nxt = (s_r.cnt == s_r.modv) ? s_r.init : CNT_W'(s_r.cnt + 1'b1);
    assign reload = wrap || |(match & s_r.ch_irl);

    // Bus transfer completes in the cycle pready is high
    assign wr_fire = psel && penable && pwrite && s_r.pready;
    assign rd_fire = psel && penable && !pwrite && s_r.pready;
    assign wv = lane_merge(rv, pwdata, pstrb);

    // Channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            fpt_channel u_ch (
                .ref_clk(ref_clk),
                .reset(reset),
                .step(step),
                .cnt_nxt(cnt_nxt),
                .ch_value(s_r.chv[gi*CNT_W +: CNT_W]),
                .toggle_en(s_r.ch_tog[gi]),
                .match(match[gi]),
                .pin_out(ch_out[gi])
            );
        end
    endgenerate

    // Register read mux and address decode
    always_comb begin
        rv = '0;
        hit = 1'b1;
        case (paddr)
            OFS_STATUS_CONTROL: begin
                rv[SC_RUN_BIT] = s_r.run;
                rv[SC_IRQ_EN_BIT] = s_r.irq_en;
                rv[SC_FLAG_BIT] = s_r.flag;
            end
            OFS_COUNT: rv[CNT_W-1:0] = s_r.cnt;
            OFS_MODULO_VALUE: rv[CNT_W-1:0] = s_r.mod_buf;
            OFS_COUNTER_INITIAL: rv[CNT_W-1:0] = s_r.init_buf;
            OFS_TIMER_CONFIGURATION: begin
                rv[TIMER_CONFIGURATION_THR_LSB +: THR_W] = s_r.thr;
                rv[TIMER_CONFIGURATION_DBG_LSB +: 2] = s_r.dbg_sel;
            end
            OFS_LOAD_ENABLE: begin
                rv[NUM_CH-1:0] = s_r.load_sel;
                rv[LOAD_OK_BIT] = s_r.load_ok;
            end
            OFS_EVENT_STATUS: rv[EV_W-1:0] = s_r.ev_st;
            OFS_EVENT_CLEAR: rv = '0;
            OFS_EVENT_ENABLE: rv[EV_W-1:0] = s_r.ev_en;
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NUM_CH; i++) begin
                    if (paddr == OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE) begin
                        hit = 1'b1;
                        rv[CH_TOGGLE_BIT] = s_r.ch_tog[i];
                        rv[CH_IRELOAD_BIT] = s_r.ch_irl[i];
                    end
                    if (paddr == OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE + OFS_CH_VALUE) begin
                        hit = 1'b1;
                        rv[CNT_W-1:0] = s_r.chv_buf[i*CNT_W +: CNT_W];
                    end
                end
            end
        endcase
    end

    // Flag clear needs an armed read and a zero written to the flag lane
    assign clr_ok = wr_fire && paddr == OFS_STATUS_CONTROL && s_r.clr_armed
        && !wv[SC_FLAG_BIT];

    // Overflow threshold decides when an overflow sets the flag
    assign ovf_set = wrap && (s_r.thr == '0
        || THR_W'(s_r.ovf_cnt + 1'b1) == s_r.thr);

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = psel && penable && !s_r.pready;
        s_nxt.pslverr = psel && penable && !s_r.pready && !hit;
        s_nxt.prdata = (psel && penable && !s_r.pready && !pwrite) ? rv : '0;

        // Counter
        if (step) begin
            s_nxt.cnt = cnt_nxt;
        end

        // Overflow counting toward the threshold
        if (wrap) begin
            if (ovf_set) begin
                s_nxt.ovf_cnt = '0;
            end else begin
                s_nxt.ovf_cnt = THR_W'(s_r.ovf_cnt + 1'b1);
            end
        end

        // Buffered transfer at a reload point, then load-ok drops
        if (reload && s_r.load_ok) begin
            s_nxt.modv = s_r.mod_buf;
            s_nxt.init = s_r.init_buf;
            for (int i = 0; i < NUM_CH; i++) begin
                if (s_r.load_sel[i]) begin
                    s_nxt.chv[i*CNT_W +: CNT_W] = s_r.chv_buf[i*CNT_W +: CNT_W];
                end
            end
            s_nxt.load_ok = 1'b0;
        end

        // Read of status-control with the flag set arms the clear
        if (rd_fire && paddr == OFS_STATUS_CONTROL && s_r.flag) begin
            s_nxt.clr_armed = 1'b1;
        end

        // Software writes
        if (wr_fire) begin
            case (paddr)
                OFS_STATUS_CONTROL: begin
                    s_nxt.run = wv[SC_RUN_BIT];
                    s_nxt.irq_en = wv[SC_IRQ_EN_BIT];
                    s_nxt.clr_armed = 1'b0;
                end
                OFS_MODULO_VALUE: s_nxt.mod_buf = wv[CNT_W-1:0];
                OFS_COUNTER_INITIAL: s_nxt.init_buf = wv[CNT_W-1:0];
                OFS_TIMER_CONFIGURATION: begin
                    s_nxt.thr = wv[TIMER_CONFIGURATION_THR_LSB +: THR_W];
                    s_nxt.dbg_sel = wv[TIMER_CONFIGURATION_DBG_LSB +: 2];
                end
                OFS_LOAD_ENABLE: begin
                    s_nxt.load_sel = wv[NUM_CH-1:0];
                    s_nxt.load_ok = wv[LOAD_OK_BIT];
                end
                OFS_EVENT_ENABLE: s_nxt.ev_en = wv[EV_W-1:0];
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (paddr == OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE) begin
                            s_nxt.ch_tog[i] = wv[CH_TOGGLE_BIT];
                            s_nxt.ch_irl[i] = wv[CH_IRELOAD_BIT];
                        end
                        if (paddr == OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE + OFS_CH_VALUE) begin
                            s_nxt.chv_buf[i*CNT_W +: CNT_W] = wv[CNT_W-1:0];
                        end
                    end
                end
            endcase
        end

        // Flag: clear first, a new set in the same cycle wins
        if (clr_ok) begin
            s_nxt.flag = 1'b0;
        end
        if (ovf_set) begin
            s_nxt.flag = 1'b1;
        end

        // Sticky events, set wins over write-one-to-clear
        if (wr_fire && paddr == OFS_EVENT_CLEAR) begin
            s_nxt.ev_st = s_r.ev_st & ~wv[EV_W-1:0];
        end
        s_nxt.ev_st = s_nxt.ev_st | {match, wrap};

        // Level interrupt from the next state, so it tracks the enabled flag and enabled events with no lag
        s_nxt.irq = (s_nxt.flag && s_nxt.irq_en) || |(s_nxt.ev_st & s_nxt.ev_en);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.modv <= RST_MODULO;
            s_r.mod_buf <= RST_MODULO;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;

    // Halted counter holds its value
    property p_debug_halt;
        @(posedge ref_clk) disable iff (reset)
        (debug_active && s_r.dbg_sel != DBG_MODE_RUN) |=> s_r.cnt == $past(s_r.cnt);
    endproperty
    a_debug_halt: assert property (p_debug_halt)
        else $error("counter moved while halted for debug");

    // Load-ok lane untouched keeps load-ok when no reload happens
    property p_narrow_load;
        @(posedge ref_clk) disable iff (reset)
        (wr_fire && paddr == OFS_LOAD_ENABLE && !pstrb[1] && !reload)
            |=> s_r.load_ok == $past(s_r.load_ok);
    endproperty
    a_narrow_load: assert property (p_narrow_load)
        else $error("narrow write changed load-ok");

    // Transfer when armed, none when not
    property p_transfer;
        @(posedge ref_clk) disable iff (reset)
        reload |=> s_r.modv == ($past(s_r.load_ok) ? $past(s_r.mod_buf) : $past(s_r.modv));
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("modulo transfer does not follow load-ok");

    // Cleared load-ok leaves active values alone at a reload point
    property p_load_block;
        @(posedge ref_clk) disable iff (reset)
        (reload && !s_r.load_ok) |=> s_r.modv == $past(s_r.modv)
            && s_r.init == $past(s_r.init) && s_r.chv == $past(s_r.chv);
    endproperty
    a_load_block: assert property (p_load_block)
        else $error("active values changed with load-ok clear");

    // No second match on channel 0 right after a match
    property p_single_match;
        @(posedge ref_clk) disable iff (reset)
        (match[0] && s_r.modv != s_r.init) |=> !match[0];
    endproperty
    a_single_match: assert property (p_single_match)
        else $error("spurious second match on channel 0");

    // Reload channel yields no second match right after its own
    property p_irl_single;
        @(posedge ref_clk) disable iff (reset)
        (match[1] && s_r.ch_irl[1] && s_r.modv != s_r.init) |=> !match[1];
    endproperty
    a_irl_single: assert property (p_irl_single)
        else $error("spurious second match on reload channel 1");

    // Toggle output changes only after a toggle-enabled match
    property p_toggle;
        @(posedge ref_clk) disable iff (reset)
        ##1 ch_out[0] != $past(ch_out[0]) |-> $past(match[0] && s_r.ch_tog[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("channel 0 output changed without a toggle match");

    // Match coincident with a reload of another channel still lands once
    property p_coincident;
        @(posedge ref_clk) disable iff (reset)
        (match[0] && match[1] && s_r.ch_irl[1] && s_r.modv != s_r.init)
            |=> s_r.ev_st[1] ##0 !match[0];
    endproperty
    a_coincident: assert property (p_coincident)
        else $error("coincident match not single");

    // Armed clear takes effect unless a new flag set arrives
    property p_flag_clear;
        @(posedge ref_clk) disable iff (reset)
        (clr_ok && !ovf_set) |=> !s_r.flag ##1 (s_r.flag -> $past(ovf_set));
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("overflow flag clear not honoured");

    // Threshold zero flags every overflow
    property p_threshold;
        @(posedge ref_clk) disable iff (reset)
        (wrap && s_r.thr == '0) |=> s_r.flag;
    endproperty
    a_threshold: assert property (p_threshold)
        else $error("overflow did not set flag with zero threshold");

    // Interrupt tracks enabled flag and enabled events, both ways
    property p_irq;
        @(posedge ref_clk) disable iff (reset)
        irq == ((s_r.flag && s_r.irq_en) || |(s_r.ev_st & s_r.ev_en));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow enabled flag");

    // Wrap returns to initial value
    property p_wrap;
        @(posedge ref_clk) disable iff (reset)
        wrap |=> s_r.cnt == $past(s_r.init) && s_r.ev_st[0];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to initial value");

    // Counter steps by one below the wrap point
    property p_count_up;
        @(posedge ref_clk) disable iff (reset)
        (step && !wrap) |=> s_r.cnt == CNT_W'($past(s_r.cnt) + 1'b1);
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance by one");

    // Full-word write sets every load-enable field
    property p_full_load;
        @(posedge ref_clk) disable iff (reset)
        (wr_fire && paddr == OFS_LOAD_ENABLE && pstrb == 4'hF)
            |=> s_r.load_ok == $past(pwdata[LOAD_OK_BIT])
            && s_r.load_sel == $past(pwdata[NUM_CH-1:0]);
    endproperty
    a_full_load: assert property (p_full_load)
        else $error("full-word load-enable write incomplete");
endmodule

// file: test/fpt_testbench.sv
// Testbench: register-level tests of the PWM compare timer over APB
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fpt_pkg::*;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic debug_active = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [NUM_CH-1:0] ch_out;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    time t1;
    time t2;
    int tg0;
    int tg1;
    logic same;

    localparam logic [7:0] A_CH0_CTL = OFS_CH_BASE;
    localparam logic [7:0] A_CH0_VAL = OFS_CH_BASE + OFS_CH_VALUE;
    localparam logic [7:0] A_CH1_CTL = OFS_CH_BASE + OFS_CH_STRIDE;
    localparam logic [7:0] A_CH1_VAL = OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_VALUE;

    // Clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    fpt_timer dut_u (
        .ref_clk(ref_clk),
        .reset(reset),
        .debug_active(debug_active),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .ch_out(ch_out)
    );

    // Verdict and end of run
    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 70000) begin
            err_count++;
            conclude();
        end
    end

    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        `CHK(nm, exp, rd)
    endtask

    // Counts pin toggles over n cycles
    task automatic tog(input int n);
        logic [NUM_CH-1:0] prev;
        prev = ch_out;
        tg0 = 0;
        tg1 = 0;
        same = 1'b1;
        repeat (n) begin
            @(posedge ref_clk);
            if (ch_out[0] !== prev[0]) tg0++;
            if (ch_out[1] !== prev[1]) tg1++;
            if (ch_out[0] !== ch_out[1]) same = 1'b0;
            prev = ch_out;
        end
    endtask

    // Waits for a rising edge of the interrupt
    task automatic wait_rise(output time t);
        do @(posedge ref_clk); while (irq !== 1'b0);
        do @(posedge ref_clk); while (irq !== 1'b1);
        t = $time;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd_chk("sc reset", OFS_STATUS_CONTROL, 32'h0000_0000);
        rd_chk("mod reset", OFS_MODULO_VALUE, {16'h0000, RST_MODULO});
        rd_chk("timer_configuration reset", OFS_TIMER_CONFIGURATION, 32'h0000_0000);
        rd_chk("load reset", OFS_LOAD_ENABLE, 32'h0000_0000);
        apb(1'b0, 8'h3C, 32'h0000_0000, 4'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0000_0000, rd)
        wr32(OFS_COUNT, 32'h0000_1234);
        rd_chk("count read only", OFS_COUNT, 32'h0000_0000);
        `CHK("mapped no error", 1'b0, er)
        // Buffered values, intermediate reload on channel 1
        wr32(OFS_MODULO_VALUE, 32'h0000_0009);
        wr32(OFS_COUNTER_INITIAL, 32'h0000_0002);
        wr32(A_CH0_VAL, 32'h0000_0007);
        wr32(A_CH1_VAL, 32'h0000_0007);
        wr32(A_CH0_CTL, 32'h0000_0001);
        wr32(A_CH1_CTL, 32'h0000_0003);
        wr32(OFS_LOAD_ENABLE, 32'h0000_0203);
        rd_chk("load full", OFS_LOAD_ENABLE, 32'h0000_0203);
        rd_chk("ch1 control", A_CH1_CTL, 32'h0000_0003);
        rd_chk("ch0 buffer", A_CH0_VAL, 32'h0000_0007);
        rd_chk("init buffer", OFS_COUNTER_INITIAL, 32'h0000_0002);
        rd_chk("clear reads zero", OFS_EVENT_CLEAR, 32'h0000_0000);
        apb(1'b1, OFS_LOAD_ENABLE, 32'h0000_0003, 4'h1);
        rd_chk("load byte", OFS_LOAD_ENABLE, 32'h0000_0203);
        apb(1'b1, OFS_LOAD_ENABLE, 32'h0000_0203, 4'h3);
        rd_chk("load half", OFS_LOAD_ENABLE, 32'h0000_0203);
        rd_chk("count idle", OFS_COUNT, 32'h0000_0000);
        wr32(OFS_EVENT_ENABLE, 32'h0000_0001);
        wr32(OFS_STATUS_CONTROL, 32'h0000_0001);
        // First wrap from full range loads the buffers
        wait_rise(t1);
        rd_chk("load ok cleared", OFS_LOAD_ENABLE, 32'h0000_0003);
        rd_chk("flag each wrap", OFS_STATUS_CONTROL, 32'h0000_0081);
        tog(80);
        `CHK("ch0 toggles", 10, tg0)
        `CHK("ch1 toggles", 10, tg1)
        `CHK("pins together", 1'b1, same)
        rd_chk("events", OFS_EVENT_STATUS, 32'h0000_0007);
        wr32(OFS_EVENT_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        `CHK("irq masked", 1'b0, irq)
        // New modulo stays in its buffer while load-ok is clear
        wr32(OFS_MODULO_VALUE, 32'h0000_0011);
        rd_chk("mod buffered", OFS_MODULO_VALUE, 32'h0000_0011);
        // Debug session: select zero runs, nonzero halts
        debug_active <= 1'b1;
        tog(40);
        `CHK("debug run", 5, tg0)
        wr32(OFS_TIMER_CONFIGURATION, 32'h0000_0040);
        repeat (2) @(posedge ref_clk);
        tog(40);
        `CHK("debug halt", 0, tg0)
        wr32(OFS_EVENT_CLEAR, 32'h0000_0007);
        rd_chk("events cleared", OFS_EVENT_STATUS, 32'h0000_0000);
        // Flag clear while halted, threshold 31
        wr32(OFS_TIMER_CONFIGURATION, 32'h0000_005F);
        rd_chk("flag armed", OFS_STATUS_CONTROL, 32'h0000_0081);
        wr32(OFS_STATUS_CONTROL, 32'h0000_0041);
        rd_chk("flag cleared", OFS_STATUS_CONTROL, 32'h0000_0041);
        `CHK("irq off", 1'b0, irq)
        debug_active <= 1'b0;
        wait_rise(t1);
        rd_chk("flag irq", OFS_STATUS_CONTROL, 32'h0000_00C1);
        `CHK("irq on", 1'b1, irq)
        repeat (10) @(posedge ref_clk);
        wr32(OFS_STATUS_CONTROL, 32'h0000_0041);
        rd_chk("clear across wrap", OFS_STATUS_CONTROL, 32'h0000_0041);
        repeat (2) @(posedge ref_clk);
        `CHK("irq follows flag", 1'b0, irq)
        wait_rise(t2);
        `CHK("overflow interval", 64'd6200, t2 - t1)
        conclude();
    end
endmodule
